// file: verilog/cec_pkg.sv
// cec_pkg: constants of the CAN error-confinement and status block
// assumes a 32-bit classic Wishbone register bus, byte addresses
package cec_pkg;

  // register byte offsets
  localparam logic [7:0] ERR_CNT_OFS  = 8'h00;
  localparam logic [7:0] STATUS_OFS   = 8'h04;
  localparam logic [7:0] IRQ_FLAG_OFS = 8'h08;
  localparam logic [7:0] MODE_OFS     = 8'h0C;

  // error counter register fields
  localparam int TEC_LSB = 8;
  localparam int REC_LSB = 0;

  // status register bits
  localparam int ST_WARN_BIT  = 0;
  localparam int ST_PASS_BIT  = 1;
  localparam int ST_BOFF_BIT  = 2;
  localparam int ST_STOVF_BIT = 3;
  localparam int ST_CFG_BIT   = 7;

  // global interrupt flag bits
  localparam int IF_WARN_BIT  = 0;
  localparam int IF_PASS_BIT  = 1;
  localparam int IF_BOFF_BIT  = 2;
  localparam int IF_STOVF_BIT = 3;

  // mode control bits
  localparam int MC_CFG_BIT    = 0;
  localparam int MC_TSTERR_BIT = 1;

  // reset values
  localparam logic [1:0] MODE_RST     = 2'h0;
  localparam logic [3:0] IRQ_FLAG_RST = 4'h0;
  localparam logic [8:0] TEC_RST      = 9'h000;
  localparam logic [7:0] REC_RST      = 8'h00;

  // fault confinement limits
  localparam logic [8:0] TEC_BUS_OFF    = 9'h100;
  localparam logic [8:0] TEC_PASSIVE    = 9'h080;
  localparam logic [8:0] TEC_WARN       = 9'h060;
  localparam logic [7:0] REC_PASSIVE    = 8'h80;
  localparam logic [7:0] REC_WARN       = 8'h60;
  localparam logic [7:0] REC_RX_OK_LOAD = 8'h7F;
  localparam logic [7:0] REC_RECOVER    = 8'h80;
  localparam logic [8:0] TEC_STEP_ERR   = 9'h008;
  localparam logic [7:0] REC_STEP_ERR8  = 8'h08;

  // one-hot confinement states
  typedef enum logic [2:0] {
    CEC_ACTIVE  = 3'b001,
    CEC_PASSIVE = 3'b010,
    CEC_BUS_OFF = 3'b100
  } cec_state_t;

endpackage : cec_pkg

// file: verilog/cec_error_confinement.sv
// cec_error_confinement: error counters, confinement state, status and flags of a CAN controller
// assumes a protocol engine giving one-cycle event pulses and a classic Wishbone master
// Behaviour
// - stamp-overflow status sets on any timer overflow and stays until cleared
// - stamp-overflow status is read-only; cleared only by clearing its interrupt flag
// - transmit count reaching 256 enters bus-off and sets bus-off status
// - in bus-off neither transmission nor reception is allowed
// - after recovery the block returns to bus-on by itself, clearing bus-off status
// - error-passive status bit 1 reads 1 only in error-passive mode
// - warning status reads 1 when either count exceeds 96
// - error counter register: transmit count bits 15-8, receive count bits 7-0
// - counter writes accepted only when the test error mode bit is 1
// - permitted write loads the low data byte into both counts
// - counts move up and down per the CAN 2.0B fault confinement rules
// - receive count stops incrementing beyond the passive limit of 128
// - receive count of 128 or more with a good reception becomes 127
// - in bus-off each 11 recessive bits increment the receive count
// - recovery count reaching 128 returns to active and clears both counts
// - bus-off recovery leaves the configuration registers unchanged
// - entering configuration mode clears both counts
// - error counter bits 31-16 read zero; software writes zero
// - interrupt flags clear on writing 1; writing 0 does nothing
// - configuration-mode status reads 1 while in configuration mode
//
// Decided for this implementation: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
module cec_error_confinement (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // protocol engine events, one-cycle pulses
  input  wire logic        tx_error_i,
  input  wire logic        tx_ok_i,
  input  wire logic        rx_error_i,
  input  wire logic        rx_error8_i,
  input  wire logic        rx_ok_i,
  input  wire logic        recessive11_i,
  input  wire logic        stamp_overflow_i,
  // status towards the protocol engine
  output logic             bus_on_o,
  output logic             error_passive_o,
  output logic             config_mode_o
);

  logic [8:0]  tec_reg;
  logic [8:0]  tec_next;
  logic [7:0]  rec_reg;
  logic [7:0]  rec_next;
  logic [1:0]  mode_reg;
  logic        cfg_prev_reg;
  logic [3:0]  irq_flag_reg;
  logic        stamp_overflow_status_reg;
  logic        ack_reg;
  logic [31:0] dat_reg;
  logic [31:0] rd_data;
  cec_pkg::cec_state_t state_reg;
  cec_pkg::cec_state_t state_next;

  logic req;
  logic wr;
  logic cfg_enter;
  logic cnt_write;
  logic flag_write;
  logic recover;
  logic warning_status;
  logic stamp_clear;

  // bus handshake: one wait state, ack for one cycle, write acts at the ack edge
  assign req        = cyc_i & stb_i & ~ack_reg;
  assign wr         = cyc_i & stb_i & we_i & ack_reg;
  assign cnt_write  = wr & sel_i[0] & (adr_i == cec_pkg::ERR_CNT_OFS)
                      & mode_reg[cec_pkg::MC_TSTERR_BIT];
  assign flag_write = wr & sel_i[0] & (adr_i == cec_pkg::IRQ_FLAG_OFS);
  assign stamp_clear = flag_write & dat_i[cec_pkg::IF_STOVF_BIT];
  assign cfg_enter  = mode_reg[cec_pkg::MC_CFG_BIT] & ~cfg_prev_reg;
  assign recover    = (state_reg == cec_pkg::CEC_BUS_OFF) & recessive11_i
                      & (rec_reg == (cec_pkg::REC_RECOVER - 8'h01));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req;
    end
  end
  assign ack_o = ack_reg;

  // counter next values
  always_comb begin
    tec_next = tec_reg;
    rec_next = rec_reg;
    if (cfg_enter) begin
      tec_next = cec_pkg::TEC_RST;
      rec_next = cec_pkg::REC_RST;
    end else if (cnt_write) begin
      tec_next = {1'b0, dat_i[7:0]};
      rec_next = dat_i[7:0];
    end else if (state_reg == cec_pkg::CEC_BUS_OFF) begin
      if (recover) begin
        tec_next = cec_pkg::TEC_RST;
        rec_next = cec_pkg::REC_RST;
      end else if (recessive11_i) begin
        rec_next = rec_reg + 8'h01;
      end
    end else if (!mode_reg[cec_pkg::MC_CFG_BIT]) begin
      if (tx_error_i) begin
        if (tec_reg >= (cec_pkg::TEC_BUS_OFF - cec_pkg::TEC_STEP_ERR)) begin
          tec_next = cec_pkg::TEC_BUS_OFF;
        end else begin
          tec_next = tec_reg + cec_pkg::TEC_STEP_ERR;
        end
      end else if (tx_ok_i && tec_reg != 9'h000) begin
        tec_next = tec_reg - 9'h001;
      end
      if (rx_error8_i && rec_reg < cec_pkg::REC_PASSIVE) begin
        rec_next = rec_reg + cec_pkg::REC_STEP_ERR8;
      end else if (rx_error_i && rec_reg < cec_pkg::REC_PASSIVE) begin
        rec_next = rec_reg + 8'h01;
      end else if (rx_ok_i) begin
        if (rec_reg >= cec_pkg::REC_PASSIVE) begin
          rec_next = cec_pkg::REC_RX_OK_LOAD;
        end else if (rec_reg != 8'h00) begin
          rec_next = rec_reg - 8'h01;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tec_reg <= cec_pkg::TEC_RST;
      rec_reg <= cec_pkg::REC_RST;
    end else begin
      tec_reg <= tec_next;
      // bus-off entry restarts the receive count as the recovery counter
      if (state_reg != cec_pkg::CEC_BUS_OFF && tec_next >= cec_pkg::TEC_BUS_OFF) begin
        rec_reg <= cec_pkg::REC_RST;
      end else begin
        rec_reg <= rec_next;
      end
    end
  end

  // confinement state
  always_comb begin
    case (state_reg)
      cec_pkg::CEC_BUS_OFF: begin
        if (recover || cfg_enter) begin
          state_next = cec_pkg::CEC_ACTIVE;
        end else begin
          state_next = cec_pkg::CEC_BUS_OFF;
        end
      end
      cec_pkg::CEC_ACTIVE, cec_pkg::CEC_PASSIVE: begin
        if (tec_next >= cec_pkg::TEC_BUS_OFF) begin
          state_next = cec_pkg::CEC_BUS_OFF;
        end else if (tec_next >= cec_pkg::TEC_PASSIVE || rec_next >= cec_pkg::REC_PASSIVE) begin
          state_next = cec_pkg::CEC_PASSIVE;
        end else begin
          state_next = cec_pkg::CEC_ACTIVE;
        end
      end
      default: begin
        state_next = cec_pkg::CEC_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= cec_pkg::CEC_ACTIVE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign warning_status = (tec_reg > cec_pkg::TEC_WARN) | (rec_reg > cec_pkg::REC_WARN);

  // mode control: only software changes it, recovery never touches it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_reg     <= cec_pkg::MODE_RST;
      cfg_prev_reg <= 1'b0;
    end else begin
      cfg_prev_reg <= mode_reg[cec_pkg::MC_CFG_BIT];
      if (wr && sel_i[0] && adr_i == cec_pkg::MODE_OFS) begin
        mode_reg <= dat_i[1:0];
      end
    end
  end

  // global interrupt flags: set wins over a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_flag_reg <= cec_pkg::IRQ_FLAG_RST;
    end else begin
      irq_flag_reg <= (irq_flag_reg & ~(flag_write ? dat_i[3:0] : 4'h0))
                      | {stamp_overflow_i,
                         state_next == cec_pkg::CEC_BUS_OFF && state_reg != cec_pkg::CEC_BUS_OFF,
                         state_next == cec_pkg::CEC_PASSIVE && state_reg != cec_pkg::CEC_PASSIVE,
                         warning_status};
    end
  end

  // sticky stamp-overflow status, cleared only through its flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stamp_overflow_status_reg <= 1'b0;
    end else if (stamp_overflow_i) begin
      stamp_overflow_status_reg <= 1'b1;
    end else if (stamp_clear) begin
      stamp_overflow_status_reg <= 1'b0;
    end
  end

  // read mux, unmapped addresses read zero
  always_comb begin
    rd_data = 32'h0000_0000;
    case (adr_i)
      cec_pkg::ERR_CNT_OFS: begin
        rd_data[cec_pkg::TEC_LSB +: 8] = tec_reg[7:0];
        rd_data[cec_pkg::REC_LSB +: 8] = rec_reg;
      end
      cec_pkg::STATUS_OFS: begin
        rd_data[cec_pkg::ST_WARN_BIT]  = warning_status;
        rd_data[cec_pkg::ST_PASS_BIT]  = (state_reg == cec_pkg::CEC_PASSIVE);
        rd_data[cec_pkg::ST_BOFF_BIT]  = (state_reg == cec_pkg::CEC_BUS_OFF);
        rd_data[cec_pkg::ST_STOVF_BIT] = stamp_overflow_status_reg;
        rd_data[cec_pkg::ST_CFG_BIT]   = mode_reg[cec_pkg::MC_CFG_BIT];
      end
      cec_pkg::IRQ_FLAG_OFS: begin
        rd_data[3:0] = irq_flag_reg;
      end
      cec_pkg::MODE_OFS: begin
        rd_data[1:0] = mode_reg;
      end
      default: begin
        rd_data = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_reg <= 32'h0000_0000;
    end else if (req) begin
      dat_reg <= rd_data;
    end
  end
  assign dat_o = dat_reg;

  assign bus_on_o        = (state_reg != cec_pkg::CEC_BUS_OFF);
  assign error_passive_o = (state_reg == cec_pkg::CEC_PASSIVE);
  assign config_mode_o   = mode_reg[cec_pkg::MC_CFG_BIT];

endmodule : cec_error_confinement

// file: sim/cec_asserts.sv
// cec_asserts: port-level checks of the error-confinement block
// bound to cec_error_confinement, sees only its ports
`timescale 1ns/1ps
module cec_asserts (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        tx_error_i,
  input wire logic        recessive11_i,
  input wire logic        bus_on_o,
  input wire logic        error_passive_o,
  input wire logic        config_mode_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_due_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack missing");
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  cnt_hi_a: assert property (ack_o && !we_i && adr_i == cec_pkg::ERR_CNT_OFS
    |-> dat_o[31:16] == 16'h0000) else $error("counter upper half not zero");
  st_rd_a: assert property (ack_o && !we_i && adr_i == cec_pkg::STATUS_OFS
    |-> dat_o[cec_pkg::ST_PASS_BIT] == $past(error_passive_o)
    && dat_o[cec_pkg::ST_BOFF_BIT] == !$past(bus_on_o)) else $error("status mismatch");
  off_pass_a: assert property (!bus_on_o |-> !error_passive_o)
    else $error("passive while bus-off");
  boff_in_a: assert property ($fell(bus_on_o) |-> $past(tx_error_i) && $past(error_passive_o))
    else $error("bus-off without cause");
  boff_hold_a: assert property (!bus_on_o && !recessive11_i && !config_mode_o |=> !bus_on_o)
    else $error("bus-off left early");
  boff_out_a: assert property ($rose(bus_on_o) |-> $past(recessive11_i) || config_mode_o)
    else $error("bus-on without recovery");
  cfg_clr_a: assert property ($rose(config_mode_o) |=> bus_on_o && !error_passive_o)
    else $error("config entry kept counts");
endmodule : cec_asserts

// file: sim/cec_can_nodes.sv
// cec_can_nodes: other bus nodes, seen as protocol event pulses
// pulses change just after the rising edge of the block's clock
`timescale 1ns/1ps
module cec_can_nodes (
  input  wire logic clk_i,
  output logic      tx_error_o,
  output logic      tx_ok_o,
  output logic      rx_error_o,
  output logic      rx_error8_o,
  output logic      rx_ok_o,
  output logic      recessive11_o,
  output logic      stamp_overflow_o
);
  logic [6:0] ev = 7'h00;
  assign {stamp_overflow_o, recessive11_o, rx_ok_o, rx_error8_o, rx_error_o, tx_ok_o,
          tx_error_o} = ev;
  // one-cycle pulses of one kind, one idle cycle between them
  task automatic send(input int k, input int n);
    repeat (n) begin
      @(posedge clk_i);
      ev <= 7'h01 << k;
      @(posedge clk_i);
      ev <= 7'h00;
    end
  endtask : send
endmodule : cec_can_nodes

// file: sim/tb_top.sv
// tb_top: register-level tests of the error-confinement block
// a classic Wishbone master here, bus events come from cec_can_nodes
`timescale 1ns/1ps
bind cec_error_confinement cec_asserts u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .dat_o(dat_o), .ack_o(ack_o), .tx_error_i(tx_error_i), .recessive11_i(recessive11_i),
  .bus_on_o(bus_on_o), .error_passive_o(error_passive_o), .config_mode_o(config_mode_o));
module tb_top;
  localparam int TXE = 0, TXO = 1, RXE = 2, RX8 = 3, RXO = 4, R11 = 5, OVF = 6;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        req = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat, dat_o;
  logic        ack_o, bus_on_o, pas_o, cfg_o;
  logic [6:0]  ev;
  int          num_errors = 0, n_tests = 0, cycles = 0;
  always #10 clk_i = ~clk_i;
  cec_can_nodes u_nodes (.clk_i(clk_i), .tx_error_o(ev[0]), .tx_ok_o(ev[1]),
    .rx_error_o(ev[2]), .rx_error8_o(ev[3]), .rx_ok_o(ev[4]), .recessive11_o(ev[5]),
    .stamp_overflow_o(ev[6]));
  cec_error_confinement u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(req), .stb_i(req),
    .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o),
    .tx_error_i(ev[0]), .tx_ok_i(ev[1]), .rx_error_i(ev[2]), .rx_error8_i(ev[3]),
    .rx_ok_i(ev[4]), .recessive11_i(ev[5]), .stamp_overflow_i(ev[6]),
    .bus_on_o(bus_on_o), .error_passive_o(pas_o), .config_mode_o(cfg_o));
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    req  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rdat = dat_o;
    req  <= 1'b0;
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0000_0000);
    check(rdat, exp);
  endtask : rd
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      give_verdict();
    end
  end
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h00, 32'h0000_0000);
    rd(8'h04, 32'h0000_0000);
    rd(8'h10, 32'h0000_0000);
    wb(1'b1, 8'h00, 32'h0000_0055);
    rd(8'h00, 32'h0000_0000);
    $display("test reset and locked counters done");
    wb(1'b1, 8'h0C, 32'h0000_0002);
    wb(1'b1, 8'h00, 32'h0000_0061);
    rd(8'h00, 32'h0000_6161);
    rd(8'h04, 32'h0000_0001);
    wb(1'b1, 8'h00, 32'h0000_0060);
    rd(8'h04, 32'h0000_0000);
    wb(1'b1, 8'h00, 32'h0000_007F);
    u_nodes.send(RX8, 1);
    rd(8'h00, 32'h0000_7F87);
    rd(8'h04, 32'h0000_0003);
    u_nodes.send(RXE, 2);
    rd(8'h00, 32'h0000_7F87);
    u_nodes.send(RXO, 1);
    u_nodes.send(TXO, 1);
    rd(8'h00, 32'h0000_7E7F);
    $display("test counting done");
    wb(1'b1, 8'h00, 32'h0000_00F8);
    u_nodes.send(TXE, 1);
    // the state register updates at the edge that send returns on; look one edge later
    @(posedge clk_i);
    check({31'h0, bus_on_o}, 32'h0);
    rd(8'h04, 32'h0000_0005);
    u_nodes.send(R11, 127);
    rd(8'h04, 32'h0000_0005);
    u_nodes.send(R11, 1);
    rd(8'h00, 32'h0000_0000);
    rd(8'h04, 32'h0000_0000);
    rd(8'h0C, 32'h0000_0002);
    $display("test bus-off recovery done");
    wb(1'b1, 8'h00, 32'h0000_0090);
    rd(8'h04, 32'h0000_0003);
    wb(1'b1, 8'h0C, 32'h0000_0003);
    rd(8'h04, 32'h0000_0080);
    rd(8'h00, 32'h0000_0000);
    wb(1'b1, 8'h0C, 32'h0000_0000);
    $display("test configuration mode done");
    u_nodes.send(OVF, 1);
    rd(8'h04, 32'h0000_0008);
    wb(1'b1, 8'h04, 32'h0000_0000);
    wb(1'b1, 8'h08, 32'h0000_0000);
    rd(8'h04, 32'h0000_0008);
    wb(1'b1, 8'h08, 32'h0000_0008);
    rd(8'h04, 32'h0000_0000);
    $display("test stamp overflow done");
    give_verdict();
  end
endmodule : tb_top
